// file: design/icmec_pkg.sv
// Constants for the cascaded interrupt controller command-word block.
// Assumes a byte-wide host port synchronous to the system clock.
// What this block does
// - Master cascade word marks inputs carrying slaves
// - Slave keeps cascade word bits 2..0 as identity
// - Mode word sets fully nested and auto EOI
// - Mask bit n governs request input n
// - Mask one blocks input, zero allows it
// - Slave mask bits govern system levels 8..15
// - EOI word bits 7..5 select the function
// - Level field used only with specific-level flag
// - Enable and mask bit both one: special mask
// - Enable one, bit zero: normal; enable zero: unchanged
// - Poll bit makes next even-port read return poll data
// - Read-select 10 picks request register on even reads
// - Read-select 11 picks in-service; bit1 zero keeps
// - After init word, three odd writes load config
// - Odd-port read returns interrupt mask register
// - Read selection persists except in polled operation
// - Special mask: only masked and in-service levels inhibited
package icmec_pkg;
    localparam int unsigned NUM_LEVELS = 8;
    // Even-port write decode
    localparam int unsigned INIT_BIT        = 4;
    localparam int unsigned OCW_SEL_BIT     = 3;
    // End-of-interrupt word fields
    localparam int unsigned ROT_BIT         = 7;
    localparam int unsigned SPEC_BIT        = 6;
    localparam int unsigned EOI_BIT         = 5;
    localparam int unsigned LVL_HI          = 2;
    // Status-select word fields
    localparam int unsigned SMASK_EN_BIT    = 6;
    localparam int unsigned SMASK_BIT       = 5;
    localparam int unsigned POLL_BIT        = 2;
    localparam int unsigned RR_BIT          = 1;
    localparam int unsigned RIS_BIT         = 0;
    // Mode word fields
    localparam int unsigned SFN_BIT         = 4;
    localparam int unsigned AUTO_END_OF_INTERRUPT_BIT        = 1;
    // End-of-interrupt function codes {rotate, specific, eoi}
    localparam logic [2:0] CMD_NS_EOI       = 3'h1;
    localparam logic [2:0] CMD_SP_EOI       = 3'h3;
    localparam logic [2:0] CMD_ROT_NS_EOI   = 3'h5;
    localparam logic [2:0] CMD_ROT_AUTO_SET = 3'h4;
    localparam logic [2:0] CMD_ROT_AUTO_CLR = 3'h0;
    localparam logic [2:0] CMD_ROT_SP_EOI   = 3'h7;
    localparam logic [2:0] CMD_SET_PRIO     = 3'h6;
    // Reset and initialization values
    localparam logic [7:0] MASK_INIT        = 8'h00;
    localparam logic [7:0] CASCADE_INIT     = 8'h02;
    localparam logic [2:0] LOWEST_INIT      = 3'h7;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;
    // Initialization sequencer, one-hot
    typedef enum logic [3:0] {
        ICMEC_READY    = 4'h1,
        ICMEC_WAIT_VEC = 4'h2,
        ICMEC_WAIT_CAS = 4'h4,
        ICMEC_WAIT_MOD = 4'h8
    } icmec_state_t;
endpackage

// file: design/icmec_prio_pick.sv
// Rotating priority picker for eight interrupt levels.
// Assumes lowest_i names the level holding lowest priority.
`timescale 1ns/1ps
module icmec_prio_pick (
    input  wire logic [7:0] vec_i,     // Candidate levels
    input  wire logic [2:0] lowest_i,  // Level of lowest priority
    output logic            valid_o,   // Any candidate present
    output logic [2:0]      level_o    // Highest-priority candidate
);
    ////////////////////////////////////////////////////////////////////////////
    // Scan from the level after the lowest, wrapping round
    always_comb begin
        logic [2:0] idx;
        idx     = 3'h0;
        valid_o = 1'b0;
        level_o = 3'h0;
        for (int k = icmec_pkg::NUM_LEVELS - 1; k >= 0; k--) begin
            idx = lowest_i + 3'h1 + 3'(k);
            if (vec_i[idx]) begin
                valid_o = 1'b1;
                level_o = idx;
            end
        end
    end
endmodule

// file: design/icmec_ctrl.sv
// One interrupt controller: command words, mask, in-service and poll.
// Assumes host strobes are one-cycle pulses on clk_i; requests are pins.
`timescale 1ns/1ps
module icmec_ctrl #(
    parameter bit IS_SLAVE = 1'b0                // Slave serves levels 8..15
) (
    input  wire logic       clk_i,               // 40 MHz system clock
    input  wire logic       rst_n_i,             // Async reset, active low
    input  wire logic       cs_i,                // Controller selected
    input  wire logic       a0_i,                // Port select: 0 even, 1 odd
    input  wire logic       wr_i,                // Write strobe, one cycle
    input  wire logic       rd_i,                // Read strobe, one cycle
    input  wire logic [7:0] wdata_i,             // Write data
    input  wire logic [7:0] irq_i,               // Request pins, level high
    input  wire logic       int_ack_i,           // Acknowledge pulse
    output logic      [7:0] rdata_o,             // Read data, held
    output logic            int_o,               // Interrupt to processor
    output logic      [3:0] int_level_o,         // System level pending
    output logic      [7:0] cascade_cfg_o,       // Slave map or identity
    output logic      [7:0] vector_base_o,       // Vector-base word
    output logic            special_nested_o,    // Fully nested option
    output logic            auto_eoi_o,          // Auto EOI option
    output logic            special_mask_o       // Special mask mode
);
    if (IS_SLAVE !== 1'b0 && IS_SLAVE !== 1'b1) begin : g_chk
        $error("IS_SLAVE must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and request synchronisers
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [7:0] irq_meta_q;
    logic [7:0] irr_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Level-sensitive request register, two stages from the pins
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_meta_q <= 8'h00;
            irr_q      <= 8'h00;
        end else begin
            irq_meta_q <= irq_i;
            irr_q      <= irq_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority rank: zero is highest, measured from lowest level
    function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
        rank = lvl - low - 3'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    icmec_pkg::icmec_state_t state_q, state_d;
    logic [7:0] imr_q, isr_q, isr_d, cas_q, vec_q;
    logic [2:0] lowest_q, lowest_d;
    logic       sfn_q, auto_end_of_interrupt_q, smm_q, poll_q, ris_q, rot_auto_q;
    logic       int_q;
    logic [3:0] lvl_q;
    logic [7:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Port decode
    wire wr_even  = cs_i & wr_i & ~a0_i;
    wire wr_odd   = cs_i & wr_i & a0_i;
    wire rd_even  = cs_i & rd_i & ~a0_i;
    wire rd_odd   = cs_i & rd_i & a0_i;
    wire wr_init  = wr_even & wdata_i[icmec_pkg::INIT_BIT];
    wire wr_ocw   = wr_even & ~wdata_i[icmec_pkg::INIT_BIT];
    wire wr_eoi   = wr_ocw & ~wdata_i[icmec_pkg::OCW_SEL_BIT];
    wire wr_sel   = wr_ocw & wdata_i[icmec_pkg::OCW_SEL_BIT];
    wire ready    = (state_q == icmec_pkg::ICMEC_READY);
    wire wr_mask  = wr_odd & ready;
    wire [2:0] eoi_cmd = wdata_i[icmec_pkg::ROT_BIT:icmec_pkg::EOI_BIT];
    wire [2:0] eoi_lvl = wdata_i[icmec_pkg::LVL_HI:0];

    ////////////////////////////////////////////////////////////////////////////
    // Candidates: masked inputs never compete; special mask frees others
    wire [7:0] req_eff = irr_q & ~imr_q & (smm_q ? ~isr_q : 8'hff);
    wire [7:0] isr_eff = smm_q ? (isr_q & imr_q & 8'h00) : isr_q;
    logic       req_v, isr_v;
    logic [2:0] req_l, isr_l;

    icmec_prio_pick u_req_pick (
        .vec_i    (req_eff),
        .lowest_i (lowest_q),
        .valid_o  (req_v),
        .level_o  (req_l)
    );

    icmec_prio_pick u_isr_pick (
        .vec_i    (isr_eff),
        .lowest_i (lowest_q),
        .valid_o  (isr_v),
        .level_o  (isr_l)
    );

    // Fully nested lets an equal level through, so slaves can re-interrupt
    wire rank_ok  = sfn_q ? (rank(req_l, lowest_q) <= rank(isr_l, lowest_q))
                          : (rank(req_l, lowest_q) <  rank(isr_l, lowest_q));
    wire pending  = req_v & (~isr_v | rank_ok);
    wire poll_rd  = rd_even & poll_q;
    wire take     = (int_ack_i | poll_rd) & pending;

    ////////////////////////////////////////////////////////////////////////////
    // In-service and rotation next state; acknowledge set wins over clear
    always_comb begin
        isr_d    = isr_q;
        lowest_d = lowest_q;
        if (wr_init) begin
            isr_d    = icmec_pkg::ZERO_BYTE;
            lowest_d = icmec_pkg::LOWEST_INIT;
        end else if (wr_eoi && ready) begin
            case (eoi_cmd)
                icmec_pkg::CMD_NS_EOI: begin
                    if (isr_v) isr_d[isr_l] = 1'b0;
                end
                icmec_pkg::CMD_SP_EOI: begin
                    isr_d[eoi_lvl] = 1'b0;
                end
                icmec_pkg::CMD_ROT_NS_EOI: begin
                    if (isr_v) begin
                        isr_d[isr_l] = 1'b0;
                        lowest_d     = isr_l;
                    end
                end
                icmec_pkg::CMD_ROT_SP_EOI: begin
                    isr_d[eoi_lvl] = 1'b0;
                    lowest_d       = eoi_lvl;
                end
                icmec_pkg::CMD_SET_PRIO: begin
                    lowest_d = eoi_lvl;
                end
                default: begin
                end
            endcase
        end
        if (take) begin
            if (!auto_end_of_interrupt_q) begin
                isr_d[req_l] = 1'b1;
            end
            if (auto_end_of_interrupt_q && rot_auto_q) begin
                lowest_d = req_l;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Initialization sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            icmec_pkg::ICMEC_READY:    state_d = state_q;
            icmec_pkg::ICMEC_WAIT_VEC: if (wr_odd) state_d = icmec_pkg::ICMEC_WAIT_CAS;
            icmec_pkg::ICMEC_WAIT_CAS: if (wr_odd) state_d = icmec_pkg::ICMEC_WAIT_MOD;
            icmec_pkg::ICMEC_WAIT_MOD: if (wr_odd) state_d = icmec_pkg::ICMEC_READY;
            default:                   state_d = icmec_pkg::ICMEC_READY;
        endcase
        if (wr_init) begin
            state_d = icmec_pkg::ICMEC_WAIT_VEC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, priority and in-service registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= icmec_pkg::ICMEC_READY;
            isr_q    <= icmec_pkg::ZERO_BYTE;
            lowest_q <= icmec_pkg::LOWEST_INIT;
        end else begin
            state_q  <= state_d;
            isr_q    <= isr_d;
            lowest_q <= lowest_d;
        end
    end

    // Configuration words loaded in order after the init word
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vec_q  <= icmec_pkg::ZERO_BYTE;
            cas_q  <= icmec_pkg::CASCADE_INIT;
            sfn_q  <= 1'b0;
            auto_end_of_interrupt_q <= 1'b0;
        end else if (wr_init) begin
            cas_q  <= icmec_pkg::CASCADE_INIT;
        end else if (wr_odd) begin
            if (state_q == icmec_pkg::ICMEC_WAIT_VEC) begin
                vec_q <= wdata_i;
            end
            if (state_q == icmec_pkg::ICMEC_WAIT_CAS) begin
                cas_q <= IS_SLAVE ? {5'h00, wdata_i[2:0]}
                                  : wdata_i;
            end
            if (state_q == icmec_pkg::ICMEC_WAIT_MOD) begin
                sfn_q  <= wdata_i[icmec_pkg::SFN_BIT];
                auto_end_of_interrupt_q <= wdata_i[icmec_pkg::AUTO_END_OF_INTERRUPT_BIT];
            end
        end
    end

    // Mask register; bit n governs input n
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            imr_q <= icmec_pkg::MASK_INIT;
        end else if (wr_init) begin
            imr_q <= icmec_pkg::MASK_INIT;
        end else if (wr_mask) begin
            imr_q <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status-select word: special mask, poll and read selection
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            smm_q      <= 1'b0;
            poll_q     <= 1'b0;
            ris_q      <= 1'b0;
            rot_auto_q <= 1'b0;
        end else if (wr_init) begin
            smm_q      <= 1'b0;
            poll_q     <= 1'b0;
            ris_q      <= 1'b0;
            rot_auto_q <= 1'b0;
        end else begin
            if (wr_sel && ready) begin
                if (wdata_i[icmec_pkg::SMASK_EN_BIT]) begin
                    smm_q <= wdata_i[icmec_pkg::SMASK_BIT];
                end
                if (wdata_i[icmec_pkg::RR_BIT]) begin
                    ris_q <= wdata_i[icmec_pkg::RIS_BIT];
                end
                poll_q <= wdata_i[icmec_pkg::POLL_BIT];
            end else if (poll_rd) begin
                poll_q <= 1'b0;
            end
            if (wr_eoi && ready && eoi_cmd == icmec_pkg::CMD_ROT_AUTO_SET) begin
                rot_auto_q <= 1'b1;
            end
            if (wr_eoi && ready && eoi_cmd == icmec_pkg::CMD_ROT_AUTO_CLR) begin
                rot_auto_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data: held until the next read strobe
    wire [7:0] poll_word  = {pending, 4'h0, req_l};
    wire [7:0] stat_word  = ris_q ? isr_q : irr_q;
    wire [7:0] even_word  = poll_q ? poll_word : stat_word;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= icmec_pkg::ZERO_BYTE;
        end else if (rd_even) begin
            rdata_q <= even_word;
        end else if (rd_odd) begin
            rdata_q <= imr_q;
        end
    end

    // Interrupt line and the system level it stands for
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_q <= 1'b0;
            lvl_q <= 4'h0;
        end else begin
            int_q <= pending & ready;
            lvl_q <= {IS_SLAVE, req_l};
        end
    end

    assign rdata_o          = rdata_q;
    assign int_o            = int_q;
    assign int_level_o      = lvl_q;
    assign cascade_cfg_o    = cas_q;
    assign vector_base_o    = vec_q;
    assign special_nested_o = sfn_q;
    assign auto_eoi_o       = auto_end_of_interrupt_q;
    assign special_mask_o   = smm_q;
endmodule

// file: tb/icmec_ctrl_sva.sv
// Checker for one controller: config loads, mask, special mask, levels.
// Assumes host strobes are one-cycle pulses and only top-level ports are seen.
`timescale 1ns/1ps
module icmec_ctrl_sva #(
    parameter bit IS_SLAVE = 1'b0  // Slave serves levels 8..15
) (
    input wire logic       clk_i,            // System clock
    input wire logic       rst_n_i,          // Async reset, active low
    input wire logic       cs_i,             // Controller selected
    input wire logic       a0_i,             // Port select
    input wire logic       wr_i,             // Write strobe
    input wire logic       rd_i,             // Read strobe
    input wire logic [7:0] wdata_i,          // Write data
    input wire logic [7:0] rdata_o,          // Read data
    input wire logic       int_o,            // Interrupt out
    input wire logic [3:0] int_level_o,      // Pending level
    input wire logic [7:0] cascade_cfg_o,    // Slave map or identity
    input wire logic [7:0] vector_base_o,    // Vector base
    input wire logic       special_nested_o, // Fully nested option
    input wire logic       auto_eoi_o,       // Auto EOI option
    input wire logic       special_mask_o    // Special mask mode
);
    logic [1:0] seq_q;
    logic [1:0] seq_d;
    logic [7:0] msk_q;
    logic [7:0] msk_d;
    // Decode of host writes; shadow of sequencer and mask
    wire wr_even = cs_i && wr_i && !a0_i;
    wire wr_odd  = cs_i && wr_i && a0_i;
    wire wr_init = wr_even && wdata_i[4];
    wire wr_sel  = wr_even && (seq_q == 2'h0) && !wdata_i[4] && wdata_i[3];
    assign seq_d = wr_init ? 2'h1 : (wr_odd && seq_q != 2'h0) ? seq_q + 2'h1 : seq_q;
    assign msk_d = wr_init ? 8'h00 : (wr_odd && seq_q == 2'h0) ? wdata_i : msk_q;
    // Shadow registers, wrap from 3 back to ready
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q <= 2'h0;
            msk_q <= 8'h00;
        end else begin
            seq_q <= seq_d;
            msk_q <= msk_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    a_mask_read_back: assert property (cs_i && rd_i && a0_i |=> rdata_o == msk_q)
        else $error("odd read differs from mask");
    a_cascade_load: assert property (wr_odd && seq_q == 2'h2 |=>
        cascade_cfg_o == (IS_SLAVE ? {5'h00, $past(wdata_i[2:0])} : $past(wdata_i)))
        else $error("cascade word not stored");
    a_mode_load: assert property (wr_odd && seq_q == 2'h3 |=>
        special_nested_o == $past(wdata_i[4]) && auto_eoi_o == $past(wdata_i[1]))
        else $error("mode word not stored");
    a_vector_load: assert property (wr_odd && seq_q == 2'h1 |=>
        vector_base_o == $past(wdata_i))
        else $error("vector word not stored");
    a_smask_set: assert property (wr_sel && wdata_i[6:5] == 2'h3 |=> special_mask_o)
        else $error("special mask not set");
    a_smask_clear: assert property (wr_sel && wdata_i[6:5] == 2'h2 |=> !special_mask_o)
        else $error("special mask not cleared");
    a_smask_keep: assert property (wr_sel && !wdata_i[6] |=> $stable(special_mask_o))
        else $error("special mask changed");
    a_init_clears: assert property (wr_init |=> !special_mask_o)
        else $error("init left special mask");
    a_full_mask: assert property ((msk_q == 8'hff) [*3] |-> !int_o)
        else $error("interrupt while fully masked");
    a_level_unmasked: assert property (int_o && msk_q == $past(msk_q) &&
        msk_q == $past(msk_q, 2) |-> !msk_q[int_level_o[2:0]] && int_level_o[3] == IS_SLAVE)
        else $error("interrupt on masked level");
    c_smask: cover property (wr_sel && wdata_i[6:5] == 2'h3);
    c_slave_int: cover property (int_o && int_level_o[3]);
    c_even_read: cover property (cs_i && rd_i && !a0_i);
endmodule
bind icmec_ctrl icmec_ctrl_sva #(.IS_SLAVE(IS_SLAVE)) u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_i(cs_i), .a0_i(a0_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .int_o(int_o), .int_level_o(int_level_o),
    .cascade_cfg_o(cascade_cfg_o), .vector_base_o(vector_base_o),
    .special_nested_o(special_nested_o), .auto_eoi_o(auto_eoi_o),
    .special_mask_o(special_mask_o));

// file: tb/icmec_host_model.sv
// Host processor model: byte reads and writes on the controller ports.
// Assumes strobes are taken at the rising edge after they are raised.
`timescale 1ns/1ps
module icmec_host_model (
    input  wire logic       clk_i,     // System clock
    input  wire logic [7:0] rdata_m_i, // Master read data
    input  wire logic [7:0] rdata_s_i, // Slave read data
    output logic            cs_m_o,    // Master select
    output logic            cs_s_o,    // Slave select
    output logic            a0_o,      // Port select
    output logic            wr_o,      // Write strobe
    output logic            rd_o,      // Read strobe
    output logic [7:0]      wdata_o    // Write data
);
    // Idle bus at time zero
    initial begin
        {cs_m_o, cs_s_o, a0_o, wr_o, rd_o} = 5'h00;
        wdata_o = 8'h00;
    end
    // One taking edge, then release; idle data inverted so stale bytes never match
    task automatic access(input logic sel, input logic a0, input logic wr, input logic [7:0] d);
        @(posedge clk_i);
        cs_m_o  <= ~sel;
        cs_s_o  <= sel;
        a0_o    <= a0;
        wr_o    <= wr;
        rd_o    <= ~wr;
        wdata_o <= d;
        @(posedge clk_i);
        {cs_m_o, cs_s_o, wr_o, rd_o} <= 4'h0;
        wdata_o <= ~d;
    endtask
    task automatic wr_byte(input logic sel, input logic a0, input logic [7:0] d);
        access(sel, a0, 1'b1, d);
    endtask
    // Read data is registered at the taking edge, sampled one edge later
    task automatic rd_byte(input logic sel, input logic a0, output logic [7:0] d);
        access(sel, a0, 1'b0, 8'h00);
        @(posedge clk_i);
        d = sel ? rdata_s_i : rdata_m_i;
    endtask
endmodule

// file: tb/interrupt_cascade_mask_eoi_control_tb.sv
// Testbench: master and slave controllers driven by one host model.
// Assumes the checker is bound to every controller instance.
`timescale 1ns/1ps
module interrupt_cascade_mask_eoi_control_tb;
    logic clk_i, rst_n_i, cs_m, cs_s, a0, wr, rd, ack_m, int_m, int_s, nest_m, nest_s;
    logic auto_end_of_interrupt_m, auto_end_of_interrupt_s, smask_m;
    logic [7:0] wdata, irq_m, irq_s, rd_m, rd_s, cas_m, cas_s, vec_m, v;
    logic [3:0] lvl_m, lvl_s;
    int err_count, checks_done, cycles;
    icmec_host_model host (.clk_i(clk_i), .rdata_m_i(rd_m), .rdata_s_i(rd_s), .cs_m_o(cs_m),
        .cs_s_o(cs_s), .a0_o(a0), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    icmec_ctrl #(.IS_SLAVE(1'b0)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_i(cs_m),
        .a0_i(a0), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .irq_i(irq_m), .int_ack_i(ack_m),
        .rdata_o(rd_m), .int_o(int_m), .int_level_o(lvl_m), .cascade_cfg_o(cas_m),
        .vector_base_o(vec_m), .special_nested_o(nest_m), .auto_eoi_o(auto_end_of_interrupt_m),
        .special_mask_o(smask_m));
    icmec_ctrl #(.IS_SLAVE(1'b1)) dut_s (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_i(cs_s),
        .a0_i(a0), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .irq_i(irq_s), .int_ack_i(1'b0),
        .rdata_o(rd_s), .int_o(int_s), .int_level_o(lvl_s), .cascade_cfg_o(cas_s),
        .vector_base_o(), .special_nested_o(nest_s), .auto_eoi_o(auto_end_of_interrupt_s),
        .special_mask_o());
    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Hang guard; the sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic a0s, input logic [7:0] exp, input string what);
        host.rd_byte(1'b0, a0s, v);
        chk(v, exp, what);
    endtask
    // Lets registered outputs and the request path settle
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic ack();
        @(posedge clk_i);
        ack_m <= 1'b1;
        @(posedge clk_i);
        ack_m <= 1'b0;
    endtask
    task automatic init(input logic sel, input logic [7:0] vec, cas, mode);
        host.wr_byte(sel, 1'b0, 8'h11);
        host.wr_byte(sel, 1'b1, vec);
        host.wr_byte(sel, 1'b1, cas);
        host.wr_byte(sel, 1'b1, mode);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n_i, ack_m, irq_m, irq_s} = 18'h0;
        {err_count, checks_done, cycles} = '0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(cas_m, 8'h02, "cascade reset");
        rd_chk(1'b1, 8'h00, "mask reset");
        $display("test reset done");
        init(1'b0, 8'h08, 8'h04, 8'h01);
        init(1'b1, 8'h70, 8'hfa, 8'h13);
        settle();
        chk(cas_m, 8'h04, "master map");
        chk(vec_m, 8'h08, "vector");
        chk({6'h00, nest_m, auto_end_of_interrupt_m}, 8'h00, "master mode");
        chk(cas_s, 8'h02, "slave identity");
        chk({6'h00, nest_s, auto_end_of_interrupt_s}, 8'h03, "slave mode");
        $display("test config done");
        irq_m <= 8'hff;
        irq_s <= 8'hff;
        for (int n = 0; n < 8; n++) begin
            host.wr_byte(1'b0, 1'b1, ~(8'h01 << n));
            host.wr_byte(1'b1, 1'b1, ~(8'h01 << n));
            settle();
            chk({3'h0, int_m, lvl_m}, {5'h02, n[2:0]}, "master level");
            chk({3'h0, int_s, lvl_s}, {5'h03, n[2:0]}, "slave level");
        end
        host.wr_byte(1'b0, 1'b1, 8'hff);
        settle();
        chk({7'h00, int_m}, 8'h00, "all masked");
        $display("test mask done");
        irq_m <= 8'h28;
        irq_s <= 8'h00;
        host.wr_byte(1'b0, 1'b1, 8'h00);
        host.wr_byte(1'b0, 1'b0, 8'h0a);
        settle();
        rd_chk(1'b0, 8'h28, "irr");
        rd_chk(1'b0, 8'h28, "irr again");
        ack();
        host.wr_byte(1'b0, 1'b0, 8'h0b);
        rd_chk(1'b0, 8'h08, "isr");
        host.wr_byte(1'b0, 1'b0, 8'h08);
        rd_chk(1'b0, 8'h08, "isr kept");
        host.wr_byte(1'b0, 1'b0, 8'h65);
        rd_chk(1'b0, 8'h08, "other level eoi");
        host.wr_byte(1'b0, 1'b0, 8'h63);
        rd_chk(1'b0, 8'h00, "specific eoi");
        ack();
        host.wr_byte(1'b0, 1'b0, 8'ha0);
        rd_chk(1'b0, 8'h00, "rotate eoi");
        settle();
        chk({4'h0, lvl_m}, 8'h05, "rotated top");
        ack();
        host.wr_byte(1'b0, 1'b0, 8'h40);
        rd_chk(1'b0, 8'h20, "no operation");
        host.wr_byte(1'b0, 1'b0, 8'h25);
        rd_chk(1'b0, 8'h00, "nonspecific eoi");
        host.wr_byte(1'b0, 1'b0, 8'hc7);
        host.wr_byte(1'b0, 1'b0, 8'h80);
        host.wr_byte(1'b0, 1'b0, 8'h00);
        settle();
        chk({4'h0, lvl_m}, 8'h03, "set priority");
        ack();
        host.wr_byte(1'b0, 1'b0, 8'he3);
        settle();
        chk({4'h0, lvl_m}, 8'h05, "rotate specific");
        host.wr_byte(1'b0, 1'b0, 8'hc7);
        $display("test eoi done");
        host.wr_byte(1'b0, 1'b0, 8'h0c);
        rd_chk(1'b0, 8'h83, "poll");
        rd_chk(1'b0, 8'h08, "after poll");
        host.wr_byte(1'b0, 1'b0, 8'h20);
        // Slave in auto EOI: a poll acknowledges but leaves in-service empty
        irq_s <= 8'h80;
        host.wr_byte(1'b1, 1'b0, 8'h0b);
        host.wr_byte(1'b1, 1'b0, 8'h0c);
        host.rd_byte(1'b1, 1'b0, v);
        chk(v, 8'h87, "slave poll");
        host.rd_byte(1'b1, 1'b0, v);
        chk(v, 8'h00, "auto eoi");
        $display("test poll done");
        ack();
        settle();
        chk({7'h00, int_m}, 8'h00, "nested block");
        host.wr_byte(1'b0, 1'b0, 8'h68);
        host.wr_byte(1'b0, 1'b1, 8'h08);
        settle();
        chk({3'h0, int_m, lvl_m}, 8'h15, "special mask");
        host.wr_byte(1'b0, 1'b0, 8'h08);
        settle();
        chk({7'h00, smask_m}, 8'h01, "mask mode kept");
        host.wr_byte(1'b0, 1'b0, 8'h48);
        settle();
        chk({7'h00, smask_m}, 8'h00, "mask mode reset");
        $display("test special mask done");
        report_and_stop();
    end
endmodule
